// >>> hdl/mhu_top.sv
// Contract
// - reset leaves the interface in command mode, not uart mode
// - command mode drops data port writes entirely
// - command mode data read returns last received byte
// - command 3Fh enters uart mode and queues ack FEh
// - listed commands queue FEh then their reply byte
// - other commands in command mode still queue FEh
// - uart mode data writes queue for transmit and get serialised out
// - status bit 6 shows transmit fifo full state
// - uart mode data read returns and removes next received byte
// - received byte goes to next slot; full fifo overwrites last slot
// - status bit 7 follows receive fifo state
// - command FFh in uart mode returns to command mode
// - other uart mode commands ignored, no ack
// - link is 31.25 kbaud, start, eight data, stop
// - transmit and receive each have a sixteen byte fifo
// - receive flag reads 0 with data, 1 when empty
// - receive interrupt cleared by data port read
`timescale 1ns/100ps
`include "mhu_consts.svh"
module mhu_top
  import mhu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic midi_irq,
  input wire logic midi_serial_in,
  output logic midi_serial_out
);
  localparam logic [15:0] BIT_CYC = 16'(`MHU_BIT_CYCLES);
  localparam logic [15:0] HALF_CYC = 16'(`MHU_BIT_CYCLES / 2);

  typedef struct packed {
    logic uart_mode;
    logic [7:0] last_cmd;
    logic [7:0] last_rx;
    logic reply_pend;
    logic [7:0] reply_byte;
    logic irq;
    logic [7:0] rdata;
    mhu_line_st_t tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_line;
    mhu_line_st_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_sync1;
    logic rx_sync2;
  } mhu_st_t;

  mhu_st_t s_q, s_d;
  logic tx_push, tx_pop, tx_empty, tx_full;
  logic [7:0] tx_head;
  logic rx_push, rx_pop, rx_empty, rx_full;
  logic [7:0] rx_push_data, rx_head;

  function automatic logic cmd_has_reply(input logic [7:0] c);
    cmd_has_reply = (c[7:3] == 5'h14) || (c == 8'hAB) || (c == 8'hAC) ||
                    (c == 8'hAD) || (c == 8'hAF);
  endfunction

  function automatic logic [7:0] cmd_reply(input logic [7:0] c);
    case (c)
      8'hAC: cmd_reply = `MHU_REPLY_AC;
      8'hAD: cmd_reply = `MHU_REPLY_AD;
      8'hAF: cmd_reply = `MHU_REPLY_AF;
      default: cmd_reply = `MHU_REPLY_ZERO;
    endcase
  endfunction

  // shared bit timer: a count of one marks the last cycle of a bit slot
  function automatic logic bit_end(input logic [15:0] c);
    bit_end = (c == 16'h0001);
  endfunction

  function automatic logic [15:0] cnt_dec(input logic [15:0] c);
    cnt_dec = c - 16'h0001;
  endfunction

  function automatic logic [2:0] bit_inc(input logic [2:0] b);
    bit_inc = b + 3'h1;
  endfunction

  // lsb-first shift; the fill bit enters at the top
  function automatic logic [7:0] shift_lsb(input logic [7:0] v, input logic fill);
    shift_lsb = {fill, v[7:1]};
  endfunction

  // flag bits sit above the low six bits of the last command
  function automatic logic [7:0] status_byte(input logic rx_mt, input logic tx_fl,
      input logic [7:0] cmd);
    status_byte = {2'b00, cmd[5:0]};
    status_byte[`MHU_STAT_RXBIT] = rx_mt;
    status_byte[`MHU_STAT_TXBIT] = tx_fl;
  endfunction

  // both fifos
  // a write to a full transmit fifo replaces its newest byte, as on receive
  mhu_fifo u_tx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(tx_push),
    .push_data(bus_wdata),
    .pop(tx_pop),
    .head(tx_head),
    .empty(tx_empty),
    .full(tx_full)
  );

  mhu_fifo u_rx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(rx_push),
    .push_data(rx_push_data),
    .pop(rx_pop),
    .head(rx_head),
    .empty(rx_empty),
    .full(rx_full)
  );

  assign bus_rdata = s_q.rdata;
  assign midi_irq = s_q.irq;
  assign midi_serial_out = s_q.tx_line;

  logic data_wr, data_rd, cmd_wr, rx_done;
  logic [7:0] rx_done_byte;

  always_comb begin
    s_d = s_q;
    data_wr = bus_wr && (bus_addr == `MHU_OFS_DATA);
    data_rd = bus_rd && (bus_addr == `MHU_OFS_DATA);
    cmd_wr = bus_wr && (bus_addr == `MHU_OFS_CMD);
    rx_done = 1'b0;
    rx_done_byte = s_q.rx_sh;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_push_data = `MHU_ACK_BYTE;
    tx_push = data_wr && s_q.uart_mode;
    rx_pop = data_rd && s_q.uart_mode;

    // receiver; second sync stage feeds the sampler
    s_d.rx_sync1 = midi_serial_in;
    s_d.rx_sync2 = s_q.rx_sync1;
    case (s_q.rx_st)
      MHU_LS_IDLE: begin
        if (!s_q.rx_sync2) begin
          s_d.rx_st = MHU_LS_START;
          s_d.rx_cnt = HALF_CYC;
        end
      end
      MHU_LS_START: begin
        if (bit_end(s_q.rx_cnt)) begin
          // glitch shorter than half a bit is dropped
          s_d.rx_st = s_q.rx_sync2 ? MHU_LS_IDLE : MHU_LS_DATA;
          s_d.rx_cnt = BIT_CYC;
          s_d.rx_bit = 3'h0;
        end else begin
          s_d.rx_cnt = cnt_dec(s_q.rx_cnt);
        end
      end
      MHU_LS_DATA: begin
        if (bit_end(s_q.rx_cnt)) begin
          s_d.rx_sh = shift_lsb(s_q.rx_sh, s_q.rx_sync2);
          s_d.rx_cnt = BIT_CYC;
          s_d.rx_bit = bit_inc(s_q.rx_bit);
          if (s_q.rx_bit == 3'h7) begin
            s_d.rx_st = MHU_LS_STOP;
          end
        end else begin
          s_d.rx_cnt = cnt_dec(s_q.rx_cnt);
        end
      end
      MHU_LS_STOP: begin
        if (bit_end(s_q.rx_cnt)) begin
          s_d.rx_st = MHU_LS_IDLE;
          // framing error drops the byte
          rx_done = s_q.rx_sync2;
        end else begin
          s_d.rx_cnt = cnt_dec(s_q.rx_cnt);
        end
      end
      default: s_d.rx_st = MHU_LS_IDLE;
    endcase

    // receive fifo source: command ack first, then pending reply, then serial byte
    if (cmd_wr) begin
      s_d.last_cmd = bus_wdata;
      if (!s_q.uart_mode) begin
        rx_push = 1'b1;
        rx_push_data = `MHU_ACK_BYTE;
        if (bus_wdata == `MHU_CMD_UART_ON) begin
          s_d.uart_mode = 1'b1;
        end else if (cmd_has_reply(bus_wdata)) begin
          s_d.reply_pend = 1'b1;
          s_d.reply_byte = cmd_reply(bus_wdata);
        end
      end else if (bus_wdata == `MHU_CMD_UART_OFF) begin
        s_d.uart_mode = 1'b0;
      end
    end else if (s_q.reply_pend) begin
      rx_push = 1'b1;
      rx_push_data = s_q.reply_byte;
      s_d.reply_pend = 1'b0;
    end
    if (rx_done) begin
      // a serial byte colliding with a command ack waits a cycle in the reply slot;
      // there is one slot only, so it displaces a reply still owed
      if (rx_push) begin
        s_d.reply_pend = 1'b1;
        s_d.reply_byte = rx_done_byte;
      end else begin
        rx_push = 1'b1;
        rx_push_data = rx_done_byte;
      end
    end
    if (rx_push) begin
      s_d.last_rx = rx_push_data;
    end

    // interrupt: a push in the same cycle as the clearing read wins
    if (data_rd) begin
      s_d.irq = 1'b0;
    end
    if (rx_push) begin
      s_d.irq = 1'b1;
    end

    // read data registered for the bus
    if (data_rd) begin
      s_d.rdata = s_q.uart_mode ? rx_head : s_q.last_rx;
    end else if (bus_rd) begin
      // status reads leave both fifos and the interrupt alone
      s_d.rdata = status_byte(rx_empty, tx_full, s_q.last_cmd);
    end

    // transmitter
    case (s_q.tx_st)
      MHU_LS_IDLE: begin
        s_d.tx_line = 1'b1;
        if (!tx_empty) begin
          tx_pop = 1'b1;
          s_d.tx_sh = tx_head;
          s_d.tx_line = 1'b0;
          s_d.tx_cnt = BIT_CYC;
          s_d.tx_st = MHU_LS_START;
        end
      end
      MHU_LS_START: begin
        if (bit_end(s_q.tx_cnt)) begin
          s_d.tx_line = s_q.tx_sh[0];
          s_d.tx_sh = shift_lsb(s_q.tx_sh, 1'b1);
          s_d.tx_bit = 3'h0;
          s_d.tx_cnt = BIT_CYC;
          s_d.tx_st = MHU_LS_DATA;
        end else begin
          s_d.tx_cnt = cnt_dec(s_q.tx_cnt);
        end
      end
      MHU_LS_DATA: begin
        if (bit_end(s_q.tx_cnt)) begin
          s_d.tx_cnt = BIT_CYC;
          s_d.tx_bit = bit_inc(s_q.tx_bit);
          if (s_q.tx_bit == 3'h7) begin
            s_d.tx_line = 1'b1;
            s_d.tx_st = MHU_LS_STOP;
          end else begin
            s_d.tx_line = s_q.tx_sh[0];
            s_d.tx_sh = shift_lsb(s_q.tx_sh, 1'b1);
          end
        end else begin
          s_d.tx_cnt = cnt_dec(s_q.tx_cnt);
        end
      end
      MHU_LS_STOP: begin
        if (bit_end(s_q.tx_cnt)) begin
          s_d.tx_st = MHU_LS_IDLE;
        end else begin
          s_d.tx_cnt = cnt_dec(s_q.tx_cnt);
        end
      end
      default: s_d.tx_st = MHU_LS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.tx_line <= 1'b1;
      s_q.rx_sync1 <= 1'b1;
      s_q.rx_sync2 <= 1'b1;
      s_q.tx_st <= MHU_LS_IDLE;
      s_q.rx_st <= MHU_LS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> inc/mhu_consts.svh
`ifndef MHU_CONSTS_SVH
`define MHU_CONSTS_SVH
`define MHU_OFS_DATA 1'h0
`define MHU_OFS_CMD 1'h1
`define MHU_CMD_UART_ON 8'h3F
`define MHU_CMD_UART_OFF 8'hFF
`define MHU_ACK_BYTE 8'hFE
`define MHU_REPLY_ZERO 8'h00
`define MHU_REPLY_AC 8'h15
`define MHU_REPLY_AD 8'h01
`define MHU_REPLY_AF 8'h64
`define MHU_STAT_TXBIT 6
`define MHU_STAT_RXBIT 7
`define MHU_FIFO_DEPTH 16
`define MHU_CLK_HZ 10000000
`define MHU_BAUD_MILLI 31250000
`define MHU_BIT_CYCLES ((`MHU_CLK_HZ * 64'd1000) / `MHU_BAUD_MILLI)
`endif

// >>> inc/mhu_pkg.sv
package mhu_pkg;
  typedef enum logic [1:0] {
    MHU_LS_IDLE = 2'b00,
    MHU_LS_START = 2'b01,
    MHU_LS_DATA = 2'b10,
    MHU_LS_STOP = 2'b11
  } mhu_line_st_t;
endpackage

// >>> hdl/mhu_fifo.sv
`timescale 1ns/100ps
`include "mhu_consts.svh"
module mhu_fifo
  import mhu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] head,
  output logic empty,
  output logic full
);
  typedef struct packed {
    logic [3:0] wr;
    logic [3:0] rd;
    logic [4:0] cnt;
  } mhu_fifo_st_t;
  mhu_fifo_st_t s_q, s_d;
  logic [7:0] mem_q [0:`MHU_FIFO_DEPTH-1];
  logic do_pop;
  logic wr_en;
  logic [3:0] wr_idx;
  assign empty = (s_q.cnt == 5'h00);
  assign full = (s_q.cnt == 5'h10);
  assign head = mem_q[s_q.rd];
  assign do_pop = pop && !empty;
  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_idx = s_q.wr;
    if (do_pop) begin
      s_d.rd = s_q.rd + 4'h1;
      s_d.cnt = s_q.cnt - 5'h01;
    end
    if (push) begin
      wr_en = 1'b1;
      if (full && !do_pop) begin
        // full: newest byte replaces the last slot, count unchanged
        wr_idx = s_q.wr - 4'h1;
      end else begin
        s_d.wr = s_q.wr + 4'h1;
        s_d.cnt = s_d.cnt + 5'h01;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_idx] <= push_data;
    end
  end
endmodule

// >>> verif/mhu_monitor.sv
`timescale 1ns/100ps
module mhu_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic midi_irq,
  input wire logic midi_serial_in,
  input wire logic midi_serial_out
);
  logic u_q;
  logic [11:0] lo_q, hin_q;
  // hin_q starts saturated: the input line idles high through reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      u_q <= 1'b0;
      lo_q <= 12'h000;
      hin_q <= 12'hFFF;
    end else begin
      if (bus_wr && bus_addr) u_q <= u_q ? bus_wdata != 8'hFF : bus_wdata == 8'h3F;
      lo_q <= midi_serial_out ? 12'h000 : lo_q + 12'h001;
      hin_q <= !midi_serial_in ? 12'h000 : hin_q + {11'h000, ~&hin_q};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rst_out;
    $fell(rst) |-> midi_serial_out && !midi_irq && bus_rdata == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs");
  property p_ack_irq;
    bus_wr && bus_addr && !u_q |-> ##[1:2] midi_irq;
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("no ack irq");
  property p_reply;
    !u_q && bus_wr && bus_addr && bus_wdata == 8'hAC ##4 bus_rd && !bus_addr
      |=> bus_rdata == 8'h15;
  endproperty
  a_reply: assert property (p_reply) else $error("bad reply");
  property p_stat_rx;
    bus_wr && bus_addr && !u_q ##[1:8] (bus_rd && bus_addr && !u_q) |=> !bus_rdata[7];
  endproperty
  a_stat_rx: assert property (p_stat_rx) else $error("rx flag");
  property p_irq_clr;
    u_q && hin_q > 12'd3300 && bus_rd && !bus_addr && !bus_wr |-> ##[1:2] !midi_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept");
  property p_uart_cmd;
    u_q && bus_wr && bus_addr && !midi_irq && hin_q > 12'd3300 |=> !midi_irq [*2];
  endproperty
  a_uart_cmd: assert property (p_uart_cmd) else $error("uart ack");
  property p_bit_len;
    $rose(midi_serial_out) |-> lo_q % 12'd320 == 12'd0;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit time");
  property p_lo_max;
    lo_q < 12'd2881;
  endproperty
  a_lo_max: assert property (p_lo_max) else $error("line low");
endmodule
bind mhu_top mhu_monitor i_mon(.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .midi_irq(midi_irq), .midi_serial_in(midi_serial_in), .midi_serial_out(midi_serial_out));

// >>> verif/mhu_midi_peer.sv
`timescale 1ns/100ps
module mhu_midi_peer (
  input wire logic line_in,
  output logic line_out,
  output logic [7:0] got,
  output logic got_v
);
  localparam int BIT_NS = 32000;
  initial begin
    line_out = 1'b1;
    got_v = 1'b0;
  end
  task send(input logic [7:0] b);
    line_out = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      #BIT_NS;
    end
    line_out = 1'b1;
    #BIT_NS;
  endtask
  // no pulse on a low stop bit, so the byte stays owed in the bench
  always begin
    @(negedge line_in);
    #(BIT_NS / 2);
    for (int i = 0; i < 9; i++) begin
      #BIT_NS;
      if (i < 8) got[i] = line_in;
    end
    got_v = line_in;
    #100;
    got_v = 1'b0;
  end
endmodule

// >>> verif/mhu_tb_top.sv
`timescale 1ns/100ps
module mhu_tb_top;
  logic clk_sys, rst, bus_addr, bus_wr, bus_rd, midi_irq, rx_line, tx_line, got_v;
  logic rd_seen;
  logic [7:0] bus_wdata, bus_rdata, got, lc, last, d;
  logic [7:0] expq[$], txq[$], rxm[$];
  int failures, checks_done, cyc, seed;
  mhu_top i_dut(.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .midi_irq(midi_irq),
    .midi_serial_in(rx_line), .midi_serial_out(tx_line));
  mhu_midi_peer i_peer(.line_in(tx_line), .line_out(rx_line), .got(got), .got_v(got_v));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task push(input logic [7:0] v);
    last = v;
    if (rxm.size() < 16) rxm.push_back(v);
    else rxm[15] = v;
  endtask
  task wr(input logic a, input logic [7:0] v);
    @(posedge clk_sys);
    #10;
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(posedge clk_sys);
    #10;
    bus_wr = 1'b0;
    if (a) lc = v;
  endtask
  task rd(input logic a, input logic [7:0] e);
    @(posedge clk_sys);
    #10;
    bus_addr = a;
    bus_rd = 1'b1;
    expq.push_back(e);
    @(posedge clk_sys);
    #10;
    bus_rd = 1'b0;
  endtask
  function logic [7:0] st(input logic f);
    return {rxm.size() == 0, f, lc[5:0]};
  endfunction
  task cmd(input logic [7:0] c);
    wr(1'b1, c);
    push(8'hFE);
    if (c inside {[8'hA0:8'hA7], 8'hAB}) push(8'h00);
    if (c == 8'hAC) push(8'h15);
    if (c == 8'hAD) push(8'h01);
    if (c == 8'hAF) push(8'h64);
    repeat (2) @(posedge clk_sys);
    #10;
    chk({7'h00, midi_irq}, 8'h01);
    rd(1'b0, last);
    rd(1'b1, st(1'b0));
  endtask
  always @(posedge clk_sys) begin
    rd_seen <= bus_rd;
    cyc <= cyc + 1;
    if (cyc > 75000) begin
      failures++;
      report_and_stop();
    end
  end
  always @(negedge clk_sys) if (rd_seen) chk(bus_rdata, expq.pop_front());
  always @(posedge got_v) chk(got, txq.size() ? txq.pop_front() : ~got);
  initial begin
    seed = 59;
    {rst, bus_addr, bus_wr, bus_rd, bus_wdata, lc} = {1'b1, 19'h00000};
    repeat (4) @(posedge clk_sys);
    #10;
    rst = 1'b0;
    wr(1'b0, 8'h5A);
    for (int c = 8'hA0; c <= 8'hAF; c++) begin
      if (!(c inside {8'hA8, 8'hA9, 8'hAA, 8'hAE})) cmd(8'(c));
    end
    repeat (3) cmd(8'($random(seed)) & 8'h1F);
    wr(1'b1, 8'h3F);
    push(8'hFE);
    while (rxm.size() > 0) rd(1'b0, rxm.pop_front());
    rd(1'b1, st(1'b0));
    chk({7'h00, midi_irq}, 8'h00);
    wr(1'b1, 8'h3F);
    rd(1'b1, st(1'b0));
    repeat (18) begin
      d = 8'($random(seed));
      wr(1'b0, d);
      // the first byte leaves the fifo at once; a write to a full fifo replaces the newest
      if (txq.size() < 17) txq.push_back(d);
      else txq[16] = d;
    end
    rd(1'b1, st(1'b1));
    repeat (2) begin
      d = 8'($random(seed));
      i_peer.send(d);
      push(d);
      repeat (3) @(posedge clk_sys);
      rd(1'b0, rxm.pop_front());
    end
    while (txq.size() != 0) @(posedge clk_sys);
    rd(1'b1, st(1'b0));
    wr(1'b1, 8'hFF);
    cmd(8'hAC);
    repeat (2) @(posedge clk_sys);
    chk(8'(expq.size()), 8'h00);
    report_and_stop();
  end
endmodule
